// File: core/tpa_source.sv
// TU-3 adaptation source: elastic store, pointer, justification, AIS
`timescale 1ns/1ps
`default_nettype none
`include "tpa_regs.svh"
module tpa_source
    import tpa_pkg::*;
#(
    parameter logic K_SLOT = 1'b0,
    parameter logic SSF_CONNECTED = 1'b1,
    parameter int DEPTH = `TPA_FIFO_DEPTH
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic vc_clock_in,
    input wire logic [7:0] vc_data_in,
    input wire logic vc_frame_start_in,
    input wire logic vc_valid_in,
    output logic vc_ready_out,
    input wire logic server_signal_fail_in,
    input wire logic payload_timing_frame_start,
    input wire logic instance_activate,
    input wire logic slot_busy_in,
    output logic [7:0] group_point_data_out,
    output logic group_point_clock_out,
    output logic group_point_frame_start_out,
    output logic group_point_drive_out,
    output logic slot_owned_out,
    output logic alarm_indication_action
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam logic [CW-1:0] FILL_LOW = CW'(DEPTH / 4);
    localparam logic [CW-1:0] FILL_HIGH = CW'((3 * DEPTH) / 4);

    // Pin synchroniser lanes
    localparam int P_SSF = 0;
    localparam int P_FS = 1;
    localparam int P_ACT = 2;
    localparam int P_BUSY = 3;

    // Reset carried into the input clock domain
    logic reset_vc_meta;
    logic reset_vc;

    always_ff @(posedge vc_clock_in)
    begin
        reset_vc_meta <= reset;
        reset_vc <= reset_vc_meta;
    end

    tpa_fifo_if #(.WIDTH(9), .CW(CW)) store ();

    // Input stream enters the store on its own clock
    assign store.wr_valid = vc_valid_in;
    assign store.wr_data = {vc_frame_start_in, vc_data_in};
    assign vc_ready_out = store.wr_ready;

    tpa_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_store (
        .wr_clk(vc_clock_in),
        .wr_rst(reset_vc),
        .rd_clk(ref_clk),
        .rd_rst(reset),
        .w(store.writer),
        .r(store.reader)
    );

    // Pins from outside the payload clock
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic fs_prev;

    always_ff @(posedge ref_clk)
    begin
        pin_meta <= {slot_busy_in, instance_activate,
            payload_timing_frame_start, server_signal_fail_in};
        pin_sync <= pin_meta;
    end

    wire ssf_sync = pin_sync[P_SSF] & SSF_CONNECTED;
    wire act_sync = pin_sync[P_ACT];
    wire busy_sync = pin_sync[P_BUSY];
    wire fs_rise = pin_sync[P_FS] & ~fs_prev;

    // Frame position within the TUG-3 byte interleave
    logic slot_sel;
    logic [9:0] pos;
    tpa_just_t just;
    logic [2:0] gap;
    logic [9:0] ptr_seen;
    logic [9:0] ptr_tx;

    wire our_slot = (slot_sel == K_SLOT);
    wire pos_last = (pos == `TPA_TU3_LAST);
    wire at_h1 = our_slot & (pos == `TPA_POS_H1);
    wire at_h2 = our_slot & (pos == `TPA_POS_H2);
    wire at_h3 = our_slot & (pos == `TPA_POS_H3);
    wire at_first = our_slot & (pos == `TPA_POS_PAY);
    wire in_pay = our_slot & (pos >= `TPA_POS_PAY);

    wire next_slot_sel = fs_rise ? 1'b0 : ~slot_sel;
    wire [9:0] pos_step = pos_last ? 10'h000 : pos + 10'h001;
    wire [9:0] next_pos = fs_rise ? 10'h000 : (our_slot ? pos_step : pos);

    // Justification from store fill, at most once per gap of frames
    wire gap_ok = (gap >= `TPA_JUST_GAP);
    wire fill_low = store.rd_count < FILL_LOW;
    wire fill_high = store.rd_count > FILL_HIGH;
    tpa_just_t next_just;
    assign next_just = (gap_ok & fill_low) ? TPA_JS_POS :
        ((gap_ok & fill_high) ? TPA_JS_NEG : TPA_JS_IDLE);

    // Reads: payload bytes, less a skipped one, plus one at H3
    wire skip_first = at_first & (just == TPA_JS_POS);
    wire extra_h3 = at_h3 & (just == TPA_JS_NEG);
    wire want_read = (in_pay & ~skip_first) | extra_h3;
    wire pop = want_read & store.rd_valid;
    assign store.rd_ready = want_read;

    wire rd_fs = store.rd_data[8];
    wire [7:0] rd_byte = store.rd_valid ? store.rd_data[7:0] : 8'h00;
    wire [9:0] pay_offset = pos - `TPA_POS_PAY;

    // Pointer bytes, with I or D bits flipped in a justification frame
    // At H1 this frame's decision and pointer are not yet registered
    wire at_h1_idle = at_h1 & (next_just == TPA_JS_IDLE);
    wire [9:0] ptr_now = at_h1_idle ? ptr_seen : ptr_tx;
    tpa_just_t just_now;
    assign just_now = at_h1 ? next_just : just;
    wire [15:0] ptr_word = tpa_ptr_word(ptr_now, just_now);

    wire [7:0] slot_byte =
        at_h1 ? ptr_word[15:8] :
        at_h2 ? ptr_word[7:0] :
        extra_h3 ? rd_byte :
        skip_first ? 8'h00 :
        in_pay ? rd_byte : 8'h00;

    wire drive_next = our_slot & act_sync & ~busy_sync;
    wire [7:0] next_data = ~drive_next ? 8'h00 :
        (alarm_indication_action ? 8'hff : slot_byte);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            fs_prev <= 1'b0;
            slot_sel <= 1'b0;
            pos <= 10'h000;
        end
        else
        begin
            fs_prev <= pin_sync[P_FS];
            slot_sel <= next_slot_sel;
            pos <= next_pos;
        end
    end

    // Justification state and spacing counter
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            just <= TPA_JS_IDLE;
            gap <= 3'h0;
        end
        else if (at_h1)
        begin
            just <= next_just;
            if (next_just != TPA_JS_IDLE)
            begin
                gap <= 3'h0;
            end
            else if (!gap_ok)
            begin
                gap <= gap + 3'h1;
            end
        end
    end

    // Offset of the VC-3 frame start as it leaves the store
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ptr_seen <= 10'h000;
            ptr_tx <= 10'h000;
        end
        else
        begin
            if (pop && rd_fs)
            begin
                ptr_seen <= in_pay ? pay_offset : 10'h000;
            end
            if (at_h1 && next_just == TPA_JS_IDLE)
            begin
                ptr_tx <= ptr_seen;
            end
        end
    end

    // Access point outputs
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            group_point_data_out <= 8'h00;
            group_point_clock_out <= 1'b0;
            group_point_frame_start_out <= 1'b0;
            group_point_drive_out <= 1'b0;
            slot_owned_out <= 1'b0;
            alarm_indication_action <= 1'b0;
        end
        else
        begin
            group_point_data_out <= next_data;
            group_point_clock_out <= our_slot;
            group_point_frame_start_out <= at_h1;
            group_point_drive_out <= drive_next;
            slot_owned_out <= act_sync & ~busy_sync;
            alarm_indication_action <= ssf_sync;
        end
    end

    ais_ones_a: assert property (@(posedge ref_clk) disable iff (reset)
        (alarm_indication_action && drive_next)
        |=> group_point_data_out == 8'hff)
        else $error("alarm did not force all ones");

    ais_follow_a: assert property (@(posedge ref_clk) disable iff (reset)
        $changed(ssf_sync) |-> ##[1:2]
        (alarm_indication_action == ssf_sync))
        else $error("alarm lags server fail");

    ais_budget_a: assert property (@(posedge ref_clk)
        disable iff (reset)
        (SSF_CONNECTED && $rose(server_signal_fail_in))
        |-> ##[1:4] alarm_indication_action)
        else $error("alarm slower than its budget");

    ssf_open_a: assert property (@(posedge ref_clk) disable iff (reset)
        !SSF_CONNECTED |-> !alarm_indication_action)
        else $error("alarm raised with fail input unconnected");

    inactive_quiet_a: assert property (@(posedge ref_clk)
        disable iff (reset)
        !act_sync |=> !group_point_drive_out && group_point_data_out == 0)
        else $error("inactive instance drove the slot");

    busy_refused_a: assert property (@(posedge ref_clk) disable iff (reset)
        busy_sync |=> !group_point_drive_out && !slot_owned_out)
        else $error("busy timeslot was taken");

    size_bits_a: assert property (@(posedge ref_clk) disable iff (reset)
        (group_point_frame_start_out && group_point_drive_out &&
        !$past(alarm_indication_action))
        |-> group_point_data_out[3:2] == `TPA_SS_TU3)
        else $error("pointer size bits wrong");

    ptr_h2_a: assert property (@(posedge ref_clk)
        disable iff (reset) (at_h1 && drive_next)
        ##2 (at_h2 && drive_next && !alarm_indication_action)
        |=> group_point_data_out == ptr_word[7:0])
        else $error("second pointer byte missing");

    pos_skip_a: assert property (@(posedge ref_clk) disable iff (reset)
        skip_first |-> !store.rd_ready && slot_byte == 8'h00)
        else $error("read during positive justification");

    neg_read_a: assert property (@(posedge ref_clk) disable iff (reset)
        (at_h3 && just == TPA_JS_NEG) |-> store.rd_ready)
        else $error("no extra read in negative justification");

    slot_alt_a: assert property (@(posedge ref_clk) disable iff (reset)
        (our_slot && !fs_rise) |=> !our_slot)
        else $error("timeslot not interleaved");

    pos_wrap_a: assert property (@(posedge ref_clk) disable iff (reset)
        (our_slot && pos_last && !fs_rise) |=> pos == 10'h000)
        else $error("frame position did not wrap at 768");

    just_gap_a: assert property (@(posedge ref_clk) disable iff (reset)
        (at_h1 && next_just != TPA_JS_IDLE) |-> gap_ok)
        else $error("justifications too close");

    pos_just_c: cover property (@(posedge ref_clk) disable iff (reset)
        skip_first && drive_next);
    neg_just_c: cover property (@(posedge ref_clk) disable iff (reset)
        extra_h3 && pop);
    ais_c: cover property (@(posedge ref_clk) disable iff (reset)
        alarm_indication_action && group_point_drive_out);
    frame_c: cover property (@(posedge ref_clk) disable iff (reset)
        pop && rd_fs && in_pay);
endmodule
`default_nettype wire

// File: shared/tpa_regs.svh
// Constants of the TU-3 adaptation source
// Behaviour
// - VC-3 bytes and frame starts enter the store on the input clock.
// - Store is read on the payload clock, frame position and justification.
// - Positive justification skips one read; byte after H3 holds no data.
// - Negative justification reads one extra byte into the H3 position.
// - Pointer goes into H1 and H2 with size bits set to binary 10.
// - Pointer takes two overhead bytes per frame at a fixed position.
// - Pointer value gives the VC-3 frame start offset within the payload.
// - One instance serves one TU-3 timeslot, A or B, chosen by parameter.
// - Only one instance may drive a timeslot; others are refused access.
// - Timeslot is driven only while activation is true.
// - Alarm follows server fail; all ones and normal data within 250 us.
// - An unconnected server fail input counts as false.
// - The TU-3 timeslot holds 768 access point bytes per frame.
`ifndef TPA_REGS_SVH
`define TPA_REGS_SVH

`define TPA_TU3_BYTES 10'h300
`define TPA_TU3_LAST 10'h2ff
`define TPA_VC3_BYTES 10'h2fd
`define TPA_POS_H1 10'h000
`define TPA_POS_H2 10'h001
`define TPA_POS_H3 10'h002
`define TPA_POS_PAY 10'h003
`define TPA_SS_TU3 2'h2
`define TPA_NDF_NORM 4'h6
`define TPA_I_BITS 10'h2aa
`define TPA_D_BITS 10'h155
`define TPA_FIFO_DEPTH 32
`define TPA_JUST_GAP 3'h4
`define TPA_CLK_NS 100
`define TPA_AIS_US 250
`define TPA_AIS_CYC ((`TPA_AIS_US * 1000) / `TPA_CLK_NS)

`endif

// File: shared/tpa_pkg.sv
// Types and helpers of the TU-3 adaptation source
`default_nettype none
`include "tpa_regs.svh"
package tpa_pkg;

    typedef enum logic [2:0] {
        TPA_JS_IDLE = 3'b001,
        TPA_JS_POS = 3'b010,
        TPA_JS_NEG = 3'b100
    } tpa_just_t;

    function automatic logic [15:0] tpa_ptr_word(
        input logic [9:0] ptr,
        input tpa_just_t js
    );
        logic [9:0] flip;
        flip = 10'h000;
        if (js == TPA_JS_POS)
        begin
            flip = `TPA_I_BITS;
        end
        else if (js == TPA_JS_NEG)
        begin
            flip = `TPA_D_BITS;
        end
        return {`TPA_NDF_NORM, `TPA_SS_TU3, ptr ^ flip};
    endfunction

endpackage
`default_nettype wire

// File: shared/tpa_fifo_if.sv
// Write and read sides of the elastic store
`timescale 1ns/1ps
`default_nettype none
interface tpa_fifo_if #(
    parameter int WIDTH = 9,
    parameter int CW = 6
);
    logic wr_valid;
    logic wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [WIDTH-1:0] rd_data;
    logic [CW-1:0] rd_count;

    modport writer (input wr_valid, input wr_data, output wr_ready);
    modport reader (input rd_ready, output rd_valid, output rd_data,
        output rd_count);
endinterface
`default_nettype wire

// File: core/tpa_mem.sv
// Two-clock store memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tpa_mem #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32,
    parameter int AW = 5
)
(
    input wire logic wr_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_clk,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] cells [DEPTH];

    always_ff @(posedge wr_clk)
    begin
        if (wr_en)
        begin
            cells[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk)
    begin
        rd_data <= cells[rd_addr];
    end
endmodule
`default_nettype wire

// File: core/tpa_fifo.sv
// Dual-clock elastic store with gray-coded pointers
`timescale 1ns/1ps
`default_nettype none
module tpa_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
)
(
    input wire logic wr_clk,
    input wire logic wr_rst,
    input wire logic rd_clk,
    input wire logic rd_rst,
    tpa_fifo_if.writer w,
    tpa_fifo_if.reader r
);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [AW:0] from_gray(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    logic [AW:0] wbin, wgray, rgray_meta, rgray_sync;
    logic [AW:0] rbin, rgray, wgray_meta, wgray_sync;
    logic full, empty;

    // Write side, input clock
    wire push = w.wr_valid & ~full;
    wire [AW:0] next_wbin = wbin + {{AW{1'b0}}, push};
    wire [AW:0] next_wgray = to_gray(next_wbin);
    wire [AW:0] full_mark = {~rgray_sync[AW:AW-1], rgray_sync[AW-2:0]};

    always_ff @(posedge wr_clk)
    begin
        rgray_meta <= rgray;
        rgray_sync <= rgray_meta;
        if (wr_rst)
        begin
            wbin <= '0;
            wgray <= '0;
            full <= 1'b1;
            w.wr_ready <= 1'b0;
        end
        else
        begin
            wbin <= next_wbin;
            wgray <= next_wgray;
            full <= (next_wgray == full_mark);
            w.wr_ready <= (next_wgray != full_mark);
        end
    end

    // Read side, payload clock
    wire pop = r.rd_ready & ~empty;
    wire [AW:0] next_rbin = rbin + {{AW{1'b0}}, pop};
    wire [AW:0] next_rgray = to_gray(next_rbin);
    assign r.rd_valid = ~empty;

    always_ff @(posedge rd_clk)
    begin
        wgray_meta <= wgray;
        wgray_sync <= wgray_meta;
        if (rd_rst)
        begin
            rbin <= '0;
            rgray <= '0;
            empty <= 1'b1;
            r.rd_count <= '0;
        end
        else
        begin
            rbin <= next_rbin;
            rgray <= next_rgray;
            empty <= (next_rgray == wgray_sync);
            r.rd_count <= from_gray(wgray_sync) - next_rbin;
        end
    end

    tpa_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .wr_clk(wr_clk),
        .wr_en(push),
        .wr_addr(wbin[AW-1:0]),
        .wr_data(w.wr_data),
        .rd_clk(rd_clk),
        .rd_addr(next_rbin[AW-1:0]),
        .rd_data(r.rd_data)
    );

    fifo_write_a: assert property (@(posedge wr_clk) disable iff (wr_rst)
        (w.wr_valid && !full) |=> (wbin == $past(wbin) + 1'b1))
        else $error("store write did not advance");

    fifo_no_overfill_a: assert property (@(posedge rd_clk)
        disable iff (rd_rst) r.rd_count <= DEPTH)
        else $error("store fill above depth");
endmodule
`default_nettype wire

// File: tb/tpa_vc_model.sv
// Upstream VC-3 byte source with ready handshake and slow mode
`timescale 1ns/1ps
`default_nettype none
module tpa_vc_model
(
    input wire logic vc_clock_in,
    input wire logic reset,
    input wire logic slow,
    input wire logic vc_ready_out,
    output logic [7:0] vc_data_in,
    output logic vc_frame_start_in,
    output logic vc_valid_in
);
    logic [9:0] idx;
    logic [7:0] cnt;
    logic [5:0] idle;
    logic [1:0] age;
    wire logic taken = vc_valid_in & vc_ready_out;
    wire logic last = (idx == 10'h2fc);
    wire logic [9:0] next_idx = !taken ? idx : last ? 10'h000 : idx + 10'h001;
    wire logic [7:0] next_cnt = taken ? cnt + 8'h01 : cnt;

    always_ff @(posedge vc_clock_in)
    begin
        if (reset)
        begin
            age <= 2'h0;
            idx <= 10'h000;
            cnt <= 8'h00;
            idle <= 6'h00;
            vc_valid_in <= 1'b0;
            vc_data_in <= 8'h00;
            vc_frame_start_in <= 1'b0;
        end
        else
        begin
            idx <= next_idx;
            cnt <= next_cnt;
            // Refused byte simply holds
            if (age != 2'h3)
                age <= age + 2'h1;
            else if (idle != 6'h00)
            begin
                idle <= idle - 6'h01;
                vc_data_in <= ~vc_data_in;
                vc_frame_start_in <= ~vc_frame_start_in;
            end
            else if (taken && slow)
            begin
                idle <= 6'h0c;
                vc_valid_in <= 1'b0;
                vc_data_in <= ~vc_data_in;
                vc_frame_start_in <= 1'b0;
            end
            else if (taken || !vc_valid_in)
            begin
                vc_valid_in <= 1'b1;
                vc_data_in <= next_cnt;
                vc_frame_start_in <= (next_idx == 10'h000);
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/tpa_source_test.sv
// Self-checking bench of the TU-3 adaptation source
`timescale 1ns/1ps
`default_nettype none
`define TB_EQ(what, exp, got) \
begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
$display("[ERR] %s expected %0h seen %0h", what, exp, got); end end
module tpa_source_test;
    logic ref_clk = 1'b0;
    logic vc_clock_in = 1'b0;
    logic reset = 1'b1;
    logic server_signal_fail_in = 1'b0;
    logic payload_timing_frame_start = 1'b0;
    logic instance_activate = 1'b1;
    logic slot_busy_in = 1'b0;
    logic slow = 1'b0;
    wire logic [7:0] vc_data_in;
    wire logic vc_frame_start_in;
    wire logic vc_valid_in;
    wire logic vc_ready_out;
    wire logic [7:0] group_point_data_out;
    wire logic group_point_clock_out;
    wire logic group_point_frame_start_out;
    wire logic group_point_drive_out;
    wire logic slot_owned_out;
    wire logic alarm_indication_action;
    wire logic clk2;
    wire logic alarm2;
    int n_fail = 0;
    int samples_checked = 0;
    int njn, njp, bad, zb;
    logic [7:0] fr [768];
    logic [7:0] d;
    logic f;
    time t_fs, t_prev;

    always #50 ref_clk = ~ref_clk;
    initial
    begin
        #1.3;
        forever #7.5 vc_clock_in = ~vc_clock_in;
    end

    tpa_source #(.K_SLOT(1'b0)) dut (.ref_clk, .reset, .vc_clock_in,
        .vc_data_in, .vc_frame_start_in, .vc_valid_in, .vc_ready_out,
        .server_signal_fail_in, .payload_timing_frame_start,
        .instance_activate, .slot_busy_in, .group_point_data_out,
        .group_point_clock_out, .group_point_frame_start_out,
        .group_point_drive_out, .slot_owned_out, .alarm_indication_action);
    // Second slot, fail input declared unconnected
    tpa_source #(.K_SLOT(1'b1), .SSF_CONNECTED(1'b0)) dut2 (.ref_clk,
        .reset, .vc_clock_in, .vc_data_in, .vc_frame_start_in,
        .vc_valid_in, .vc_ready_out(), .server_signal_fail_in,
        .payload_timing_frame_start, .instance_activate,
        .slot_busy_in(1'b0), .group_point_data_out(),
        .group_point_clock_out(clk2), .group_point_frame_start_out(),
        .group_point_drive_out(), .slot_owned_out(),
        .alarm_indication_action(alarm2));
    tpa_vc_model model (.vc_clock_in, .reset, .slow, .vc_ready_out,
        .vc_data_in, .vc_frame_start_in, .vc_valid_in);

    task automatic next_slot();
        for (int k = 0; k < 4; k++)
        begin
            @(posedge ref_clk);
            #1;
            if (group_point_clock_out === 1'b1)
                break;
        end
        d = group_point_data_out;
        f = group_point_frame_start_out;
    endtask

    task automatic get_frame();
        f = 1'b0;
        for (int i = 0; i < 2000 && f !== 1'b1; i++)
            next_slot();
        t_prev = t_fs;
        t_fs = $time;
        fr[0] = d;
        for (int i = 1; i < 768; i++)
        begin
            next_slot();
            fr[i] = d;
        end
    endtask

    function automatic logic [9:0] ptr_of();
        return {fr[0][1:0], fr[1]};
    endfunction

    // Classifies frames by pointer flips and follows the byte sequence
    task automatic scan(input int nfr);
        logic [9:0] p;
        logic [9:0] pprev;
        logic [7:0] lastb;
        int s;
        {njn, njp, bad, zb} = '0;
        get_frame();
        pprev = ptr_of();
        lastb = fr[767];
        repeat (nfr)
        begin
            get_frame();
            p = ptr_of();
            s = 3;
            if ((p ^ pprev) == 10'h155)
                {njn, s} = {njn + 1, 32'd2};
            else if ((p ^ pprev) == 10'h2aa)
            begin
                {njp, s} = {njp + 1, 32'd4};
                zb += (fr[3] !== 8'h00);
            end
            else
            begin
                pprev = p;
                zb += (fr[2] !== 8'h00);
            end
            for (int i = s; i < 768; i++)
            begin
                bad += (fr[i] !== lastb + 8'h01);
                lastb = fr[i];
            end
        end
    endtask

    task automatic t_frame();
        payload_timing_frame_start = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        payload_timing_frame_start = 1'b0;
        get_frame();
        get_frame();
        `TB_EQ("header bits", 6'h1a, fr[0][7:2])
        `TB_EQ("frame period", 153600, t_fs - t_prev)
        `TB_EQ("pointer range", 1'b1, ptr_of() < 10'h2fd)
        next_slot();
        `TB_EQ("slot count", 1'b1, f)
        @(posedge ref_clk);
        #1;
        `TB_EQ("slot b strobe", 1'b1, clk2)
        `TB_EQ("slot a strobe", 1'b0, group_point_clock_out)
        $display("t_frame done");
    endtask

    task automatic t_neg();
        scan(8);
        `TB_EQ("negative steps", 1'b1, njn > 0)
        `TB_EQ("step spacing", 1'b1, njn < 3)
        `TB_EQ("byte order", 0, bad)
        `TB_EQ("h3 bytes", 0, zb)
        $display("t_neg done");
    endtask

    task automatic t_pos();
        slow = 1'b1;
        scan(10);
        slow = 1'b0;
        `TB_EQ("positive steps", 1'b1, njp > 0)
        `TB_EQ("skipped bytes", 0, zb)
        $display("t_pos done");
    endtask

    task automatic wait_alarm(input logic lvl);
        for (int k = 0; k < 2500 && alarm_indication_action !== lvl; k++)
        begin
            @(posedge ref_clk);
            #1;
        end
        next_slot();
    endtask

    task automatic t_ais();
        int ones = 0;
        server_signal_fail_in = 1'b1;
        wait_alarm(1'b1);
        `TB_EQ("alarm raised", 1'b1, alarm_indication_action)
        `TB_EQ("unconnected fail", 1'b0, alarm2)
        repeat (20)
        begin
            next_slot();
            ones += (d === 8'hff);
        end
        `TB_EQ("all ones", 20, ones)
        server_signal_fail_in = 1'b0;
        wait_alarm(1'b0);
        ones = 0;
        repeat (8)
        begin
            next_slot();
            ones += (d === 8'hff);
        end
        `TB_EQ("normal data", 1'b1, ones < 8)
        $display("t_ais done");
    endtask

    task automatic settle();
        repeat (6) @(posedge ref_clk);
        next_slot();
    endtask

    task automatic t_refuse();
        slot_busy_in = 1'b1;
        settle();
        `TB_EQ("busy owned", 1'b0, slot_owned_out)
        `TB_EQ("busy drive", 1'b0, group_point_drive_out)
        `TB_EQ("busy data", 8'h00, d)
        slot_busy_in = 1'b0;
        instance_activate = 1'b0;
        settle();
        `TB_EQ("idle drive", 1'b0, group_point_drive_out)
        `TB_EQ("idle data", 8'h00, d)
        instance_activate = 1'b1;
        settle();
        `TB_EQ("active drive", 1'b1, group_point_drive_out)
        `TB_EQ("active owned", 1'b1, slot_owned_out)
        $display("t_refuse done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (80000) @(posedge ref_clk);
        n_fail++;
        $display("[ERR] watchdog expected done seen timeout");
        tally_and_finish();
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        t_frame();
        t_neg();
        t_pos();
        t_ais();
        t_refuse();
        tally_and_finish();
    end
endmodule
`default_nettype wire
